// ===== rtl/asc_pkg.sv
// Constants, register map and state type for the A/D sequence controller.
// Assumes one bus clock and an AHB-Lite slave port with 32-bit data.
package asc_pkg;

  localparam logic [7:0] OFS_CTL2     = 8'h00;
  localparam logic [7:0] OFS_CTL3     = 8'h04;
  localparam logic [7:0] OFS_CTL4     = 8'h08;
  localparam logic [7:0] OFS_SEQ_CTL  = 8'h0C;
  localparam logic [7:0] OFS_SEQ_STAT = 8'h10;
  localparam logic [7:0] OFS_TEST     = 8'h14;
  localparam logic [7:0] OFS_CMP      = 8'h18;
  localparam logic [7:0] OFS_RES0     = 8'h20;
  localparam logic [7:0] OFS_RES7     = 8'h3C;

  // Control register two fields.
  localparam int CTL2_FFC   = 6;
  localparam int CTL2_TLVL  = 4;
  localparam int CTL2_TEN   = 2;
  // Control register three fields.
  localparam int CTL3_LEN_HI = 6;
  localparam int CTL3_LEN_LO = 3;
  localparam int CTL3_WRAP   = 2;
  // Control register four field.
  localparam int CTL4_LOWRES = 7;
  // Sequence control fields.
  localparam int SC_JUST  = 7;
  localparam int SC_SIGN  = 6;
  localparam int SC_CONT  = 5;
  localparam int SC_MCH   = 4;
  localparam int SC_CH_HI = 2;
  // Sequence status fields.
  localparam int ST_DONE   = 7;
  localparam int ST_TOVR   = 5;
  localparam int ST_ROVR   = 4;
  localparam int ST_CNT_HI = 2;

  localparam logic [7:0]  CTL2_RST     = 8'h00;
  localparam logic [7:0]  CTL3_RST     = 8'h20;
  localparam logic [7:0]  CTL4_RST     = 8'h05;
  localparam logic [7:0]  SEQ_CTL_RST  = 8'h00;
  localparam logic [7:0]  TEST_RST     = 8'h00;
  localparam logic [3:0]  FULL_LEN     = 4'h8;
  localparam logic [9:0]  MSB10        = 10'h200;
  localparam logic [7:0]  MSB8         = 8'h80;

  typedef enum logic [1:0] {
    ASC_IDLE  = 2'b00,
    ASC_ISSUE = 2'b01,
    ASC_WAIT  = 2'b10
  } asc_state_t;

endpackage : asc_pkg

// ===== rtl/asc_seq_ctrl.sv
// Sequence controller and status logic of an 8-channel A/D converter.
// Assumes the analog machine converts on CONV_START and answers CONV_DONE.
//
// Overview of operation
// - A sequence control write aborts and restarts with new settings.
// - justify_right 1 right-justifies results, 0 left-justifies.
// - signed_format gives two's complement, only when left-justified.
// - 8-bit left results occupy bits 15..8, right results bits 7..0.
// - 10-bit left results occupy bits 15..6, right results bits 9..0.
// - Signed code is the unsigned code with its top bit inverted.
// - continuous_sequence repeats sequences; clear runs just one.
// - Without multi_channel every conversion samples the selected channel.
// - With multi_channel the channel starts at the code and increments.
// - Three-bit channel code covers inputs zero to seven and wraps.
// - sequence_done_flag sets at every sequence end, continuous mode too.
// - Done flag clears: write one, sequence control write, fast-clear result read.
// - In edge-trigger mode a trigger edge while a sequence runs sets trigger_overrun_flag.
// - Trigger overrun clears on write one or any control register write.
// - Writing a result whose complete flag is set sets result overrun.
// - Result overrun clears on write one, a sequence control write or a trigger start.
// - Counter points at the next result register; status writes keep it.
// - Non-wrapping mode zeroes the counter at sequence start and end.
// - Control writes that abort or start always zero the counter.
// - Test register reads back its value; writes only in special modes.
// - Wrap mode fills successive slots; else slot follows position.
// - low_resolution_select picks 8-bit results when 1, 10-bit when 0.
`timescale 1ns/10ps

module asc_seq_ctrl (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        EXT_TRIG,
  input  wire logic        SPECIAL_MODE,
  input  wire logic        CONV_DONE,
  input  wire logic [9:0]  CONV_CODE,
  output logic             CONV_START,
  output logic             CONV_ABORT,
  output logic      [2:0]  CONV_CHANNEL,
  output logic             CONV_LOW_RES,
  output logic             SEQ_ACTIVE
);

  asc_pkg::asc_state_t state_r;
  logic [7:0]  ctl2_r, ctl3_r, ctl4_r, seqc_r, test_r;
  logic        done_r, tovr_r, rovr_r, armed_r, trig_d_r;
  logic [2:0]  cnt_r, pos_r;
  logic [7:0]  cmp_r;
  logic [15:0] res_r [8];
  logic        dph_r, dwr_r;
  logic [7:0]  dad_r;

  // Sequence length of zero or above eight means eight conversions.
  function automatic logic [3:0] seq_len(input logic [3:0] f);
    seq_len = (f == 4'h0 || f > asc_pkg::FULL_LEN) ? asc_pkg::FULL_LEN : f;
  endfunction : seq_len

  function automatic logic [15:0] fmt(input logic [9:0] c, input logic lr,
                                      input logic rj, input logic sg);
    fmt = 16'h0000;
    if (rj && lr)
      fmt = {8'h00, c[7:0]};
    else if (rj)
      fmt = {6'h00, c};
    else if (lr)
      fmt = {c[7:0] ^ (sg ? asc_pkg::MSB8 : 8'h00), 8'h00};
    else
      fmt = {c ^ (sg ? asc_pkg::MSB10 : 10'h000), 6'h00};
  endfunction : fmt

  // One wait state on every transfer lets the read data come from a flop
  // and see the effect of a write that finished just before it.
  logic addr_ok, dwrite;
  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign dwrite  = dph_r && dwr_r;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dph_r     <= 1'b0;
      dwr_r     <= 1'b0;
      dad_r     <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      dph_r     <= addr_ok;
      HREADYOUT <= !addr_ok;
      HRESP     <= 1'b0;
      if (addr_ok) begin
        dwr_r <= HWRITE;
        dad_r <= HADDR[7:0];
      end
    end
  end

  logic wr_c2, wr_c3, wr_c4, wr_sc, wr_st, wr_ts, rd_res, rd_cmp;
  logic [2:0] rd_idx;
  always_comb begin
    wr_c2  = 1'b0;
    wr_c3  = 1'b0;
    wr_c4  = 1'b0;
    wr_sc  = 1'b0;
    wr_st  = 1'b0;
    wr_ts  = 1'b0;
    rd_res = 1'b0;
    rd_cmp = 1'b0;
    rd_idx = dad_r[4:2];
    if (dwrite && dad_r == asc_pkg::OFS_CTL2)
      wr_c2 = 1'b1;
    else if (dwrite && dad_r == asc_pkg::OFS_CTL3)
      wr_c3 = 1'b1;
    else if (dwrite && dad_r == asc_pkg::OFS_CTL4)
      wr_c4 = 1'b1;
    else if (dwrite && dad_r == asc_pkg::OFS_SEQ_CTL)
      wr_sc = 1'b1;
    else if (dwrite && dad_r == asc_pkg::OFS_SEQ_STAT)
      wr_st = 1'b1;
    else if (dwrite && dad_r == asc_pkg::OFS_TEST)
      wr_ts = SPECIAL_MODE;
    else if (dph_r && !dwr_r && dad_r == asc_pkg::OFS_CMP)
      rd_cmp = 1'b1;
    else if (dph_r && !dwr_r && dad_r >= asc_pkg::OFS_RES0 &&
             dad_r <= asc_pkg::OFS_RES7 && dad_r[1:0] == 2'h0)
      rd_res = 1'b1;
  end

  // Sequence events.
  logic abort_cfg, trig_edge, trig_evt, start_hw, conv_ok, last, tovr_set;
  logic [7:0] new_sc;
  assign new_sc    = HWDATA[7:0];
  assign abort_cfg = wr_c2 || wr_c3 || wr_c4;
  assign trig_edge = EXT_TRIG && !trig_d_r;
  assign trig_evt  = ctl2_r[asc_pkg::CTL2_TEN] &&
                     (ctl2_r[asc_pkg::CTL2_TLVL] ? EXT_TRIG : trig_edge);
  assign start_hw  = trig_evt && state_r == asc_pkg::ASC_IDLE &&
                     !wr_sc && !abort_cfg;
  assign tovr_set  = ctl2_r[asc_pkg::CTL2_TEN] &&
                     !ctl2_r[asc_pkg::CTL2_TLVL] && trig_edge &&
                     state_r != asc_pkg::ASC_IDLE;
  assign conv_ok   = CONV_DONE && state_r == asc_pkg::ASC_WAIT &&
                     !wr_sc && !abort_cfg;
  assign last      = {1'b0, pos_r} ==
                     seq_len(ctl3_r[asc_pkg::CTL3_LEN_HI:asc_pkg::CTL3_LEN_LO])
                     - 4'h1;

  logic cont, wrap;
  assign cont = seqc_r[asc_pkg::SC_CONT];
  assign wrap = ctl3_r[asc_pkg::CTL3_WRAP];

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctl2_r <= asc_pkg::CTL2_RST;
      ctl3_r <= asc_pkg::CTL3_RST;
      ctl4_r <= asc_pkg::CTL4_RST;
      seqc_r <= asc_pkg::SEQ_CTL_RST;
      test_r <= asc_pkg::TEST_RST;
    end else begin
      if (wr_c2)
        ctl2_r <= HWDATA[7:0];
      if (wr_c3)
        ctl3_r <= HWDATA[7:0];
      if (wr_c4)
        ctl4_r <= HWDATA[7:0];
      if (wr_sc)
        seqc_r <= new_sc;
      if (wr_ts)
        test_r <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      trig_d_r <= 1'b0;
    else
      trig_d_r <= EXT_TRIG;
  end

  // Sequence state, position and channel.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r      <= asc_pkg::ASC_IDLE;
      pos_r        <= 3'h0;
      CONV_CHANNEL <= 3'h0;
      CONV_START   <= 1'b0;
      CONV_ABORT   <= 1'b0;
      CONV_LOW_RES <= 1'b0;
      SEQ_ACTIVE   <= 1'b0;
    end else begin
      CONV_START   <= 1'b0;
      CONV_ABORT   <= (wr_sc || abort_cfg) &&
                      state_r != asc_pkg::ASC_IDLE;
      CONV_LOW_RES <= ctl4_r[asc_pkg::CTL4_LOWRES];
      if (wr_sc) begin
        state_r      <= asc_pkg::ASC_ISSUE;
        pos_r        <= 3'h0;
        CONV_CHANNEL <= new_sc[asc_pkg::SC_CH_HI:0];
        SEQ_ACTIVE   <= 1'b1;
      end else if (abort_cfg) begin
        state_r    <= asc_pkg::ASC_IDLE;
        SEQ_ACTIVE <= 1'b0;
      end else if (start_hw) begin
        state_r      <= asc_pkg::ASC_ISSUE;
        pos_r        <= 3'h0;
        CONV_CHANNEL <= seqc_r[asc_pkg::SC_CH_HI:0];
        SEQ_ACTIVE   <= 1'b1;
      end else begin
        case (state_r)
          asc_pkg::ASC_ISSUE: begin
            CONV_START <= 1'b1;
            state_r    <= asc_pkg::ASC_WAIT;
          end
          asc_pkg::ASC_WAIT: begin
            if (conv_ok && last) begin
              pos_r        <= 3'h0;
              CONV_CHANNEL <= seqc_r[asc_pkg::SC_CH_HI:0];
              if (cont) begin
                state_r <= asc_pkg::ASC_ISSUE;
              end else begin
                state_r    <= asc_pkg::ASC_IDLE;
                SEQ_ACTIVE <= 1'b0;
              end
            end else if (conv_ok) begin
              pos_r   <= pos_r + 3'h1;
              state_r <= asc_pkg::ASC_ISSUE;
              if (seqc_r[asc_pkg::SC_MCH])
                CONV_CHANNEL <= CONV_CHANNEL + 3'h1;
              // Single-channel sequences keep the selected input.
            end
          end
          default: state_r <= asc_pkg::ASC_IDLE;
        endcase
      end
    end
  end

  // Result index; in non-wrapping mode it tracks the sequence position.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      cnt_r <= 3'h0;
    else if (wr_sc || abort_cfg)
      cnt_r <= 3'h0;
    else if (start_hw && !wrap)
      cnt_r <= 3'h0;
    else if (conv_ok && last && !wrap)
      cnt_r <= 3'h0;
    else if (conv_ok)
      cnt_r <= cnt_r + 3'h1;
  end

  always_ff @(posedge CLK) begin
    if (conv_ok)
      res_r[cnt_r] <= fmt(CONV_CODE, ctl4_r[asc_pkg::CTL4_LOWRES],
                          seqc_r[asc_pkg::SC_JUST],
                          seqc_r[asc_pkg::SC_SIGN]);
  end

  // Complete flags; the set wins over a read clear in the same cycle.
  logic [7:0] cmp_clr, cmp_set;
  logic       ffc;
  assign ffc     = ctl2_r[asc_pkg::CTL2_FFC];
  assign cmp_clr = (rd_res && (ffc || armed_r)) ? (8'h01 << rd_idx) : 8'h00;
  assign cmp_set = conv_ok ? (8'h01 << cnt_r) : 8'h00;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmp_r   <= 8'h00;
      armed_r <= 1'b0;
    end else begin
      if (wr_sc)
        cmp_r <= 8'h00;
      else
        cmp_r <= (cmp_r & ~cmp_clr) | cmp_set;
      if (rd_cmp)
        armed_r <= 1'b1;
      else if (rd_res)
        armed_r <= 1'b0;
    end
  end

  // Status flags.  Hardware sets beat same-cycle clears, except that control register writes block all three flag sets.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      done_r <= 1'b0;
      tovr_r <= 1'b0;
      rovr_r <= 1'b0;
    end else begin
      if (conv_ok && last)
        done_r <= 1'b1;
      else if (wr_sc || (rd_res && ffc) ||
               (wr_st && HWDATA[asc_pkg::ST_DONE]))
        done_r <= 1'b0;
      if (tovr_set && !wr_sc && !abort_cfg)
        tovr_r <= 1'b1;
      else if (wr_sc || abort_cfg ||
               (wr_st && HWDATA[asc_pkg::ST_TOVR]))
        tovr_r <= 1'b0;
      if (conv_ok && cmp_r[cnt_r])
        rovr_r <= 1'b1;
      else if (wr_sc || start_hw ||
               (wr_st && HWDATA[asc_pkg::ST_ROVR]))
        rovr_r <= 1'b0;
    end
  end

  // Read data is sampled at the end of the wait state.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (dph_r && !dwr_r) begin
      if (dad_r == asc_pkg::OFS_CTL2)
        HRDATA <= {24'h000000, ctl2_r};
      else if (dad_r == asc_pkg::OFS_CTL3)
        HRDATA <= {24'h000000, ctl3_r};
      else if (dad_r == asc_pkg::OFS_CTL4)
        HRDATA <= {24'h000000, ctl4_r};
      else if (dad_r == asc_pkg::OFS_SEQ_CTL)
        HRDATA <= {24'h000000, seqc_r};
      else if (dad_r == asc_pkg::OFS_SEQ_STAT)
        HRDATA <= {24'h000000, done_r, 1'b0, tovr_r, rovr_r, 1'b0,
                   cnt_r};
      else if (dad_r == asc_pkg::OFS_TEST)
        HRDATA <= {24'h000000, test_r};
      else if (dad_r == asc_pkg::OFS_CMP)
        HRDATA <= {24'h000000, cmp_r};
      else if (rd_res)
        HRDATA <= {16'h0000, res_r[rd_idx]};
      else
        HRDATA <= 32'h0000_0000;
    end
  end

  // Checks.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_launch;
    state_r == asc_pkg::ASC_ISSUE ##1
      (state_r == asc_pkg::ASC_WAIT && CONV_START);
  endsequence

  a_restart_on_write: assert property (wr_sc |=> s_launch)
    else $error("sequence control write did not launch a conversion");
  a_done_at_end: assert property (conv_ok && last |=> done_r)
    else $error("done flag not set at sequence end");
  a_done_cleared: assert property (wr_sc |=> !done_r)
    else $error("done flag survived a sequence control write");
  // A trigger start in either trigger mode or a new write may legally restart from idle.
  sequence s_stay_idle;
    state_r == asc_pkg::ASC_IDLE ##1
      (state_r == asc_pkg::ASC_IDLE || $past(start_hw || wr_sc));
  endsequence

  a_counter_abort: assert property (
      (wr_sc || abort_cfg) |=> cnt_r == 3'h0)
    else $error("counter not zeroed on abort");
  a_trig_overrun: assert property (
      tovr_set && !wr_sc && !abort_cfg |=> tovr_r)
    else $error("trigger overrun not flagged");
  a_result_overrun: assert property (
      conv_ok && cmp_r[cnt_r] |=> rovr_r)
    else $error("result overrun not flagged");
  a_channel_step: assert property (
      conv_ok && !last && seqc_r[asc_pkg::SC_MCH] |=>
      CONV_CHANNEL == $past(CONV_CHANNEL) + 3'h1)
    else $error("multi-channel step wrong");
  a_channel_hold: assert property (
      conv_ok && !last && !seqc_r[asc_pkg::SC_MCH] |=>
      $stable(CONV_CHANNEL))
    else $error("single-channel sequence changed input");
  a_single_stops: assert property (
      conv_ok && last && !cont |=> s_stay_idle)
    else $error("single sequence did not stop");
  a_status_keeps_cnt: assert property (
      wr_st && !conv_ok && !start_hw |=> $stable(cnt_r))
    else $error("status write moved the counter");

endmodule : asc_seq_ctrl

// ===== sim/asc_analog_model.sv
// Behavioural analog machine facing the sequence controller.
// Assumes one-cycle start and abort pulses from the controller.
`timescale 1ns/10ps

module asc_analog_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [2:0] channel,
  input  wire logic [7:0] delay,
  input  wire logic [9:0] base,
  output logic            done,
  output logic      [9:0] code
);
  logic [7:0] cnt_r;
  logic       busy_r;
  logic [2:0] ch_r;

  // Outside a done pulse the code toggles, so a stale value never matches.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
      ch_r   <= 3'h0;
      done   <= 1'b0;
      code   <= 10'h155;
    end else begin
      done <= 1'b0;
      code <= ~code;
      if (abort) begin
        busy_r <= 1'b0;
      end else if (start) begin
        busy_r <= 1'b1;
        cnt_r  <= delay;
        ch_r   <= channel;
      end else if (busy_r && cnt_r == 8'h00) begin
        busy_r <= 1'b0;
        done   <= 1'b1;
        code   <= base + {7'h00, ch_r};
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : asc_analog_model

// ===== sim/test_adc_sequence_control_status.sv
// Self-checking bench for the A/D sequence controller.
// Assumes one AHB-Lite master and the behavioural analog machine.
`timescale 1ns/10ps

module test_adc_sequence_control_status;
  localparam logic [7:0] C2 = asc_pkg::OFS_CTL2;
  localparam logic [7:0] C3 = asc_pkg::OFS_CTL3;
  localparam logic [7:0] C4 = asc_pkg::OFS_CTL4;
  localparam logic [7:0] SC = asc_pkg::OFS_SEQ_CTL;
  localparam logic [7:0] ST = asc_pkg::OFS_SEQ_STAT;
  localparam logic [7:0] TS = asc_pkg::OFS_TEST;
  localparam logic [7:0] R0 = asc_pkg::OFS_RES0;

  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic        ext_trig, special_mode, conv_done, conv_start;
  logic        conv_abort, seq_active, conv_low_res;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize, conv_channel;
  logic [9:0]  conv_code, base;
  logic [7:0]  dly;
  int          bad_count;
  int          checks;

  asc_seq_ctrl i_dut (
    .CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .EXT_TRIG(ext_trig), .SPECIAL_MODE(special_mode),
    .CONV_DONE(conv_done), .CONV_CODE(conv_code),
    .CONV_START(conv_start), .CONV_ABORT(conv_abort),
    .CONV_CHANNEL(conv_channel), .CONV_LOW_RES(conv_low_res),
    .SEQ_ACTIVE(seq_active)
  );

  asc_analog_model i_ana (
    .clk(clk), .reset_n(reset_n), .start(conv_start), .abort(conv_abort),
    .channel(conv_channel), .delay(dly), .base(base),
    .done(conv_done), .code(conv_code)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize;
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // Called just after an edge; ends at the edge that takes the data.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : xfer

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rv);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd

  task automatic wait_st(input int b);
    int n;
    n = 0;
    do begin
      xfer(1'b0, ST, 32'h0);
      n++;
    end while (rv[b] !== 1'b1 && n < 300);
    chk("wait_status", 32'h1, {31'h0, rv[b]});
  endtask : wait_st

  task automatic trig;
    ext_trig <= 1'b1;
    repeat (2) @(posedge clk);
    ext_trig <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : trig

  function automatic logic [31:0] cd(input logic [2:0] ch);
    return {22'h0, base + {7'h00, ch}};
  endfunction : cd

  function automatic logic [31:0] fmt(input logic lr, input logic rj,
                                      input logic sg, input logic [31:0] c);
    logic [15:0] v;
    if (lr) v = rj ? {8'h00, c[7:0]} : {c[7:0] ^ {sg, 7'h00}, 8'h00};
    else v = rj ? {6'h00, c[9:0]} : {c[9:0] ^ {sg, 9'h000}, 6'h00};
    return {16'h0000, v};
  endfunction : fmt

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    summarize;
  end

  initial begin
    {reset_n, hsel, hwrite, ext_trig, special_mode} = 5'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    dly = 8'h03;
    base = 10'h2F0;
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(C3, 32'h20, "ctl3_reset");
    rd(ST, 32'h00, "status_reset");
    xfer(1'b1, C3, 32'h18);
    xfer(1'b1, SC, 32'h83);
    wait_st(7);
    for (int i = 0; i < 3; i++) rd(R0 + 8'(4 * i), cd(3), "single");
    rd(ST, 32'h80, "single_status");
    chk("single_stop", 32'h0, {31'h0, seq_active});
    // Every resolution, justification and sign pairing, channel 7 then 0.
    xfer(1'b1, C3, 32'h10);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, C4, i[2] ? 32'h85 : 32'h05);
      xfer(1'b1, SC, {24'h0, i[1], i[0], 6'h17});
      wait_st(7);
      rd(R0, fmt(i[2], i[1], i[0], cd(7)), "fmt_first");
      rd(R0 + 8'h04, fmt(i[2], i[1], i[0], cd(0)), "fmt_wrap");
      chk("low_res", {31'h0, i[2]}, {31'h0, conv_low_res});
    end
    xfer(1'b1, ST, 32'h00);
    rd(ST, 32'h80, "w0_keeps");
    xfer(1'b1, ST, 32'h80);
    rd(ST, 32'h00, "w1_clears");
    // Slow conversions leave room to observe flags mid-sequence.
    dly <= 8'h28;
    xfer(1'b1, C4, 32'h05);
    xfer(1'b1, C3, 32'h08);
    xfer(1'b1, SC, 32'h21);
    wait_st(4);
    rd(ST, 32'h90, "cont_overrun");
    chk("cont_runs", 32'h1, {31'h0, seq_active});
    xfer(1'b1, ST, 32'h10);
    rd(ST, 32'h80, "rovr_w1c");
    xfer(1'b1, SC, 32'h85);
    rd(ST, 32'h00, "restart_clears");
    wait_st(7);
    rd(R0, cd(5), "restart_new");
    xfer(1'b1, C2, 32'h40);
    xfer(1'b1, SC, 32'h82);
    wait_st(7);
    rd(R0, cd(2), "fast_res");
    rd(ST, 32'h00, "fast_clear");
    xfer(1'b1, C2, 32'h04);
    xfer(1'b1, C3, 32'h20);
    xfer(1'b1, SC, 32'h80);
    trig;
    xfer(1'b0, ST, 32'h0);
    chk("trig_overrun", 32'h20, rv & 32'hF8);
    xfer(1'b1, C3, 32'h20);
    rd(ST, 32'h00, "abort_clears");
    chk("abort_idle", 32'h0, {31'h0, seq_active});
    trig;
    chk("trig_start", 32'h1, {31'h0, seq_active});
    wait_st(7);
    xfer(1'b1, C3, 32'h1C);
    xfer(1'b1, SC, 32'h80);
    wait_st(7);
    rd(ST, 32'h83, "wrap_count");
    xfer(1'b1, ST, 32'h87);
    rd(ST, 32'h03, "count_kept");
    trig;
    wait_st(7);
    rd(ST, 32'h86, "wrap_on");
    rd(R0 + 8'h0C, cd(0), "wrap_slot");
    xfer(1'b1, SC, 32'h80);
    rd(ST, 32'h00, "ctl_zeroes");
    // Level trigger: starts from idle, never flags a trigger overrun.
    xfer(1'b1, C2, 32'h14);
    ext_trig <= 1'b1;
    repeat (4) @(posedge clk);
    chk("level_start", 32'h1, {31'h0, seq_active});
    xfer(1'b0, ST, 32'h0);
    chk("level_no_ovr", 32'h0, rv & 32'h20);
    ext_trig <= 1'b0;
    xfer(1'b1, TS, 32'h5A);
    rd(TS, 32'h00, "test_locked");
    special_mode <= 1'b1;
    xfer(1'b1, TS, 32'h5A);
    rd(TS, 32'h5A, "test_special");
    rd(8'h40, 32'h00, "unmapped");
    summarize;
  end
endmodule : test_adc_sequence_control_status
